// [rtl/sic_map.svh]
// Constants for the supply input conditioning block
`ifndef SIC_MAP_SVH
`define SIC_MAP_SVH
`define SIC_NUM_CHAN 10
`define SIC_NUM_PRIM 5
`define SIC_NUM_DUAL 5
`define SIC_THR_W 8
`define SIC_HYST_W 5
`define SIC_US_W 7
`define SIC_TIME_W 12
`define SIC_DIV_W 8
`define SIC_CLK_HZ 40000000
`define SIC_CYC_PER_US (`SIC_CLK_HZ / 1000000)
`define SIC_FILT_MAX_US 100
`define SIC_PULSE_MAX_US 100
`define SIC_REF_CLK_HZ 100000
`define SIC_DIV_HALF (`SIC_CLK_HZ / (2 * `SIC_REF_CLK_HZ))
`define SIC_PUMP_OUTS 6
`define SIC_CFG_RST 0
`endif

// [rtl/sic_pkg.sv]
// Types shared by the supply input conditioning block
`include "sic_map.svh"
package sic_pkg;
  typedef struct packed {
    logic [`SIC_THR_W-1:0]  uvTh;
    logic [`SIC_THR_W-1:0]  ovTh;
    logic [`SIC_HYST_W-1:0] hyst;
    logic                   uvEn;
    logic                   ovEn;
    logic [`SIC_US_W-1:0]   filtUs;
  } chanCfg_t;
  typedef struct packed {
    logic                 logicMode;
    logic                 edgeMode;
    logic                 pullDnEn;
    logic [`SIC_US_W-1:0] pulseUs;
  } dualCfg_t;
  typedef enum logic [1:0] {
    SRC_ENGINE = 2'b00,
    SRC_SMBUS  = 2'b01,
    SRC_CLOCK  = 2'b10,
    SRC_RSVD   = 2'b11
  } outSrc_t;
  typedef enum logic [2:0] {
    PULL_WEAK_GND    = 3'b000,
    PULL_OPEN_DRAIN  = 3'b001,
    PULL_WEAK_VDD    = 3'b010,
    PULL_STRONG_VDD  = 3'b011,
    PULL_WEAK_RAIL   = 3'b100,
    PULL_STRONG_RAIL = 3'b101,
    PULL_STRONG_GND  = 3'b110,
    PULL_PUMP        = 3'b111
  } pullStyle_t;
  typedef struct packed {
    outSrc_t    src;
    pullStyle_t style;
  } outCfg_t;
  typedef struct packed {
    logic weakDn;
    logic strongDn;
    logic weakUpVdd;
    logic strongUpVdd;
    logic weakUpRail;
    logic strongUpRail;
    logic pump;
  } drive_t;
  typedef enum logic [1:0] {
    PWR_OFF  = 2'b00,
    PWR_WEAK = 2'b01,
    PWR_LIVE = 2'b10
  } pwrState_t;
endpackage

// [rtl/glitch_filter.sv]
// Time-domain glitch filter for one detector or logic input
`timescale 1ns/1ps
`default_nettype none
`include "sic_map.svh"
module glitch_filter #(
  parameter int CW = `SIC_TIME_W
) (
  input  wire logic          clk,
  input  wire logic          rstN,
  input  wire logic          din,
  input  wire logic [CW-1:0] limit,
  output logic               dout_q
);
  logic [CW-1:0] cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  // Any return to the held level restarts the count, so bounce never accumulates
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q  <= '0;
      dout_q <= 1'b0;
    end else if (din == dout_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= limit) begin
      dout_q <= din;
      cnt_q  <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  filt_block_a: assert property ((din == dout_q) |=> $stable(dout_q))
    else $error("filter output moved while input matched it");
  filt_delay_a: assert property (!$stable(dout_q) |-> $past(cnt_q) >= $past(limit))
    else $error("filter output moved before the timeout");
  filt_count_a: assert property ((din != dout_q) && (cnt_q < limit) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("filter counter did not advance");
endmodule
`default_nettype wire

// [rtl/edge_pulser.sv]
// Level follower or edge-to-pulse converter for one logic input
`timescale 1ns/1ps
`default_nettype none
`include "sic_map.svh"
module edge_pulser #(
  parameter int CW = `SIC_TIME_W
) (
  input  wire logic          clk,
  input  wire logic          rstN,
  input  wire logic          din,
  input  wire logic          edgeMode,
  input  wire logic [CW-1:0] width,
  output logic               dout_q
);
  logic          prev_q;
  logic [CW-1:0] cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prev_q <= 1'b0;
      cnt_q  <= '0;
      dout_q <= 1'b0;
    end else begin
      prev_q <= din;
      if (!edgeMode) begin
        dout_q <= din;
        cnt_q  <= '0;
      end else if (din != prev_q) begin
        // Either transition retriggers; zero width still yields one cycle
        dout_q <= 1'b1;
        cnt_q  <= width;
      end else if (cnt_q > 1) begin
        cnt_q <= cnt_q - 1'b1;
      end else begin
        dout_q <= 1'b0;
        cnt_q  <= '0;
      end
    end
  end

  level_follow_a: assert property (!edgeMode |=> dout_q == $past(din))
    else $error("level mode output does not follow input");
  pulse_start_a: assert property (edgeMode && (din != prev_q) |=> dout_q)
    else $error("edge did not start a pulse");
  pulse_end_a: assert property (edgeMode && dout_q && (cnt_q <= 1) && (din == prev_q) |=> !dout_q)
    else $error("pulse outlived its width");
endmodule
`default_nettype wire

// [rtl/supply_input_conditioning.sv]
// Digital back end of the ten supervisor input channels and output drivers
`timescale 1ns/1ps
`default_nettype none
`include "sic_map.svh"
module supply_input_conditioning (
  input  wire logic                                      clk,
  input  wire logic                                      rstn,
  input  wire logic [`SIC_NUM_CHAN-1:0][`SIC_THR_W-1:0] supplyCode,
  input  wire logic [`SIC_NUM_DUAL-1:0]                 logicPin,
  input  wire logic                                      supplyAbove1v2,
  input  wire logic                                      supplyAbove2v7,
  input  wire logic                                      cfgLatch,
  input  wire sic_pkg::chanCfg_t [`SIC_NUM_CHAN-1:0]    chanCfgIn,
  input  wire sic_pkg::dualCfg_t [`SIC_NUM_DUAL-1:0]    dualCfgIn,
  input  wire sic_pkg::outCfg_t [`SIC_NUM_CHAN-1:0]     outCfgIn,
  input  wire logic [`SIC_NUM_CHAN-1:0]                 engineData,
  input  wire logic [`SIC_NUM_CHAN-1:0]                 smbusData,
  output logic [`SIC_NUM_CHAN-1:0]                      faultStatus_q,
  output logic [`SIC_NUM_DUAL-1:0]                      warnStatus_q,
  output logic                                          warning_q,
  output logic [`SIC_NUM_DUAL-1:0]                      logicOut_q,
  output logic [`SIC_NUM_DUAL-1:0]                      pullDownEn_q,
  output var sic_pkg::drive_t [`SIC_NUM_CHAN-1:0]       drive_q,
  output logic                                          configured_q
);
  localparam int NFILT = `SIC_NUM_CHAN + `SIC_NUM_DUAL;
  localparam sic_pkg::drive_t DRV_WEAK = '{weakDn: 1'b1, default: 1'b0};

  logic [1:0]                        rstPipe_q;
  logic                              rstSyncN;
  logic [`SIC_NUM_DUAL-1:0]          pinMeta_q;
  logic [`SIC_NUM_DUAL-1:0]          pin_q;
  logic [1:0]                        lvlMeta_q;
  logic [1:0]                        lvl_q;
  sic_pkg::pwrState_t                pwrState_q;
  sic_pkg::pwrState_t                pwrState_d;
  logic                              loadCfg;
  sic_pkg::chanCfg_t [`SIC_NUM_CHAN-1:0] chanCfg_q;
  sic_pkg::dualCfg_t [`SIC_NUM_DUAL-1:0] dualCfg_q;
  sic_pkg::outCfg_t [`SIC_NUM_CHAN-1:0]  outCfg_q;
  logic [`SIC_NUM_CHAN-1:0]          uv_q;
  logic [`SIC_NUM_CHAN-1:0]          ov_q;
  logic [NFILT-1:0]                  filtIn;
  logic [NFILT-1:0]                  filtOut;
  logic [`SIC_NUM_DUAL-1:0]          pulseOut;
  logic [`SIC_NUM_DUAL-1:0]          logicModes;
  logic [`SIC_NUM_DUAL-1:0]          pullDnEns;
  logic [`SIC_DIV_W-1:0]             div_q;
  logic                              refClk_q;

  // Caps the request at the documented maximum before scaling to cycles
  function automatic logic [`SIC_TIME_W-1:0] usToCycles(
    input logic [`SIC_US_W-1:0] us,
    input logic [`SIC_US_W-1:0] maxUs
  );
    logic [`SIC_US_W-1:0] capped;
    capped = (us > maxUs) ? maxUs : us;
    return `SIC_TIME_W'(capped * `SIC_CYC_PER_US);
  endfunction

  function automatic sic_pkg::drive_t styleDrive(
    input sic_pkg::pullStyle_t style,
    input logic                data,
    input logic                pumpOk
  );
    sic_pkg::drive_t d;
    d = '0;
    unique case (style)
      sic_pkg::PULL_WEAK_GND: d = DRV_WEAK;
      sic_pkg::PULL_OPEN_DRAIN: d.strongDn = !data;
      sic_pkg::PULL_WEAK_VDD: begin
        d.strongDn  = !data;
        d.weakUpVdd = data;
      end
      sic_pkg::PULL_STRONG_VDD: begin
        d.strongDn    = !data;
        d.strongUpVdd = data;
      end
      sic_pkg::PULL_WEAK_RAIL: begin
        d.strongDn   = !data;
        d.weakUpRail = data;
      end
      sic_pkg::PULL_STRONG_RAIL: begin
        d.strongDn     = !data;
        d.strongUpRail = data;
      end
      sic_pkg::PULL_STRONG_GND: d.strongDn = 1'b1;
      sic_pkg::PULL_PUMP: begin
        // Outputs without a pump fall back to the safe weak pull-down
        if (pumpOk) begin
          d.strongDn = !data;
          d.pump     = data;
        end else begin
          d = DRV_WEAK;
        end
      end
    endcase
    return d;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_q[1];

  // Pins and supply level flags come from outside the clock domain
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinMeta_q <= '0;
      pin_q     <= '0;
      lvlMeta_q <= 2'h0;
      lvl_q     <= 2'h0;
    end else begin
      pinMeta_q <= logicPin;
      pin_q     <= pinMeta_q;
      lvlMeta_q <= {supplyAbove2v7, supplyAbove1v2};
      lvl_q     <= lvlMeta_q;
    end
  end

  always_comb begin
    pwrState_d = pwrState_q;
    unique case (pwrState_q)
      sic_pkg::PWR_OFF: begin
        if (lvl_q[0]) begin
          pwrState_d = sic_pkg::PWR_WEAK;
        end
      end
      sic_pkg::PWR_WEAK: begin
        if (!lvl_q[0]) begin
          pwrState_d = sic_pkg::PWR_OFF;
        end else if (lvl_q[1] && cfgLatch) begin
          pwrState_d = sic_pkg::PWR_LIVE;
        end
      end
      sic_pkg::PWR_LIVE: begin
        if (!lvl_q[0]) begin
          pwrState_d = sic_pkg::PWR_OFF;
        end else if (!lvl_q[1]) begin
          pwrState_d = sic_pkg::PWR_WEAK;
        end
      end
      default: pwrState_d = sic_pkg::PWR_OFF;
    endcase
  end
  assign loadCfg = (pwrState_q == sic_pkg::PWR_WEAK) && (pwrState_d == sic_pkg::PWR_LIVE);

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pwrState_q   <= sic_pkg::PWR_OFF;
      configured_q <= 1'b0;
    end else begin
      pwrState_q   <= pwrState_d;
      configured_q <= (pwrState_d == sic_pkg::PWR_LIVE);
    end
  end

  // Configuration is captured only once the supply is healthy
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      chanCfg_q <= {`SIC_NUM_CHAN{sic_pkg::chanCfg_t'(`SIC_CFG_RST)}};
      dualCfg_q <= {`SIC_NUM_DUAL{sic_pkg::dualCfg_t'(`SIC_CFG_RST)}};
      outCfg_q  <= {`SIC_NUM_CHAN{sic_pkg::outCfg_t'(`SIC_CFG_RST)}};
    end else if (loadCfg) begin
      chanCfg_q <= chanCfgIn;
      dualCfg_q <= dualCfgIn;
      outCfg_q  <= outCfgIn;
    end
  end

  for (genvar j = 0; j < `SIC_NUM_DUAL; j++) begin : g_modes
    assign logicModes[j] = dualCfg_q[j].logicMode;
    assign pullDnEns[j]  = dualCfg_q[j].pullDnEn;
  end

  // Thresholds and hysteresis share one code scale, so hysteresis adds as steps
  for (genvar i = 0; i < `SIC_NUM_CHAN; i++) begin : g_cmp
    logic [`SIC_THR_W-1:0] code;
    logic [`SIC_THR_W:0]   uvClear;
    logic [`SIC_THR_W:0]   ovLift;
    if (i < `SIC_NUM_PRIM) begin : g_prim
      assign code = supplyCode[i];
    end else begin : g_dual
      assign code = dualCfg_q[i-`SIC_NUM_PRIM].logicMode ? supplyCode[i-`SIC_NUM_PRIM]
                                                          : supplyCode[i];
    end
    assign uvClear = {1'b0, chanCfg_q[i].uvTh} + (`SIC_THR_W+1)'(chanCfg_q[i].hyst);
    assign ovLift  = {1'b0, code} + (`SIC_THR_W+1)'(chanCfg_q[i].hyst);

    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        uv_q[i] <= 1'b0;
        ov_q[i] <= 1'b0;
      end else begin
        if (!chanCfg_q[i].uvEn) begin
          uv_q[i] <= 1'b0;
        end else if (uv_q[i]) begin
          uv_q[i] <= ({1'b0, code} <= uvClear);
        end else begin
          uv_q[i] <= (code < chanCfg_q[i].uvTh);
        end
        if (!chanCfg_q[i].ovEn) begin
          ov_q[i] <= 1'b0;
        end else if (ov_q[i]) begin
          ov_q[i] <= (ovLift >= {1'b0, chanCfg_q[i].ovTh});
        end else begin
          ov_q[i] <= (code > chanCfg_q[i].ovTh);
        end
      end
    end

    uv_hold_a: assert property (chanCfg_q[i].uvEn && uv_q[i] && ({1'b0, code} <= uvClear) |=> uv_q[i])
      else $error("under limit fault released inside hysteresis");
    ov_hold_a: assert property (chanCfg_q[i].ovEn && ov_q[i] && (ovLift >= {1'b0, chanCfg_q[i].ovTh}) |=> ov_q[i])
      else $error("upper limit fault released inside hysteresis");
    hyst_clear_a: assert property ($fell(uv_q[i]) && $past(chanCfg_q[i].uvEn)
        |-> (`SIC_THR_W+1)'($past(code)) > (`SIC_THR_W+1)'($past(chanCfg_q[i].uvTh))
            + (`SIC_THR_W+1)'($past(chanCfg_q[i].hyst)))
      else $error("under limit fault cleared below threshold plus hysteresis");
  end

  // Dual inputs route either the pin or their own detector into the shared filter
  for (genvar f = 0; f < NFILT; f++) begin : g_filt
    logic [`SIC_TIME_W-1:0] lim;
    if (f < `SIC_NUM_PRIM) begin : g_prim
      assign filtIn[f] = uv_q[f] | ov_q[f];
      assign lim = usToCycles(chanCfg_q[f].filtUs, `SIC_US_W'(`SIC_FILT_MAX_US));
    end else if (f < `SIC_NUM_CHAN) begin : g_dual
      assign filtIn[f] = logicModes[f-`SIC_NUM_PRIM] ? pin_q[f-`SIC_NUM_PRIM]
                                                     : (uv_q[f] | ov_q[f]);
      assign lim = usToCycles(chanCfg_q[f].filtUs, `SIC_US_W'(`SIC_FILT_MAX_US));
    end else begin : g_warn
      assign filtIn[f] = logicModes[f-`SIC_NUM_CHAN]
                         & (uv_q[f-`SIC_NUM_PRIM] | ov_q[f-`SIC_NUM_PRIM]);
      assign lim = usToCycles(chanCfg_q[f-`SIC_NUM_PRIM].filtUs, `SIC_US_W'(`SIC_FILT_MAX_US));
    end
    glitch_filter #(
      .CW(`SIC_TIME_W)
    ) u_filt (
      .clk   (clk),
      .rstN  (rstSyncN),
      .din   (filtIn[f]),
      .limit (lim),
      .dout_q(filtOut[f])
    );
  end

  for (genvar j = 0; j < `SIC_NUM_DUAL; j++) begin : g_pulse
    edge_pulser #(
      .CW(`SIC_TIME_W)
    ) u_pulse (
      .clk     (clk),
      .rstN    (rstSyncN),
      .din     (filtOut[`SIC_NUM_PRIM+j]),
      .edgeMode(dualCfg_q[j].edgeMode),
      .width   (usToCycles(dualCfg_q[j].pulseUs, `SIC_US_W'(`SIC_PULSE_MAX_US))),
      .dout_q  (pulseOut[j])
    );
  end

  // These registered results are what the step controller reads
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      faultStatus_q <= '0;
      warnStatus_q  <= '0;
      warning_q     <= 1'b0;
      logicOut_q    <= '0;
      pullDownEn_q  <= '0;
    end else begin
      faultStatus_q <= filtOut[`SIC_NUM_CHAN-1:0] & ~{logicModes, `SIC_NUM_PRIM'(0)};
      warnStatus_q  <= filtOut[NFILT-1:`SIC_NUM_CHAN];
      warning_q     <= |filtOut[NFILT-1:`SIC_NUM_CHAN];
      logicOut_q    <= pulseOut & logicModes;
      pullDownEn_q  <= logicModes & pullDnEns;
    end
  end

  warn_or_a: assert property (warning_q == |warnStatus_q)
    else $error("warning is not the OR of the warning detectors");
  pulldown_a: assert property (##1 pullDownEn_q == $past(logicModes & pullDnEns))
    else $error("pull-down enable does not match configuration");
  mode_excl_a: assert property (##1 (($past(logicModes) & faultStatus_q[`SIC_NUM_CHAN-1:`SIC_NUM_PRIM])
                                     == '0))
    else $error("dual input reported as detector while in logic mode");

  // Free-running reference clock for drivers that select it
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      div_q    <= '0;
      refClk_q <= 1'b0;
    end else if (div_q == `SIC_DIV_W'(`SIC_DIV_HALF - 1)) begin
      div_q    <= '0;
      refClk_q <= !refClk_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  ref_clk_a: assert property (!$stable(refClk_q) |-> $past(div_q) == `SIC_DIV_W'(`SIC_DIV_HALF - 1))
    else $error("reference clock half period is wrong");

  for (genvar k = 0; k < `SIC_NUM_CHAN; k++) begin : g_drv
    logic data;
    always_comb begin
      unique case (outCfg_q[k].src)
        sic_pkg::SRC_SMBUS: data = smbusData[k];
        sic_pkg::SRC_CLOCK: data = refClk_q;
        default: data = engineData[k];
      endcase
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        drive_q[k] <= '0;
      end else begin
        unique case (pwrState_q)
          sic_pkg::PWR_WEAK: drive_q[k] <= DRV_WEAK;
          sic_pkg::PWR_LIVE: drive_q[k] <= styleDrive(outCfg_q[k].style, data,
                                                      1'(k < `SIC_PUMP_OUTS));
          default: drive_q[k] <= '0;
        endcase
      end
    end

    ramp_weak_a: assert property ((pwrState_q != sic_pkg::PWR_LIVE) |=> (drive_q[k] & ~DRV_WEAK) == '0)
      else $error("driver active before configuration is latched");
    unprog_drive_a: assert property ((pwrState_q == sic_pkg::PWR_LIVE)
        && (outCfg_q[k].style == sic_pkg::PULL_WEAK_GND) |=> drive_q[k] == DRV_WEAK)
      else $error("cleared configuration did not give a weak pull-down");
    if (k >= `SIC_PUMP_OUTS) begin : g_nopump
      no_pump_a: assert property (!drive_q[k].pump)
        else $error("charge pump used on an output without one");
    end
  end
endmodule
`default_nettype wire

// [sim/supply_rails_model.sv]
// Behavioural model of the supply rails and logic pins around the block
`timescale 1ns/1ps
`default_nettype none
module supply_rails_model (
  input  wire logic       clk,
  input  wire logic [1:0] level,
  input  wire logic [4:0] pinDrv,
  input  wire logic [4:0] pinVal,
  input  wire logic [4:0] pullDn,
  output logic            above1v2,
  output logic            above2v7,
  output logic [4:0]      pin
);
  logic [4:0] float_q = 5'h00;
  // An undriven pin without pull-down wanders, so no stale level is seen
  always @(posedge clk) float_q <= ~float_q;
  assign above1v2 = level != 2'h0;
  assign above2v7 = level == 2'h2;
  assign pin      = (pinDrv & pinVal) | (~pinDrv & ~pullDn & float_q);
endmodule
`default_nettype wire

// [sim/tb_supply_input_conditioning.sv]
// Self-checking testbench for the supply input conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb_supply_input_conditioning;
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  logic [9:0][7:0]         supplyCode;
  logic [4:0]              pinDrv, pinVal, logicPin, warnStatus, logicOut, pullDownEn;
  logic [1:0]              level;
  logic                    above1v2, above2v7, cfgLatch, warning, configured, prev;
  sic_pkg::chanCfg_t [9:0] chanCfg;
  sic_pkg::dualCfg_t [4:0] dualCfg;
  sic_pkg::outCfg_t [9:0]  outCfg;
  logic [9:0]              engineData, smbusData, faultStatus;
  sic_pkg::drive_t [9:0]   drive;
  int                      error_cnt = 0, num_checks = 0, cycles = 0, n;
  // Indexed by output, one table per engine data level; SMBus data is driven opposite to it
  logic [6:0]              expHi [10] = '{7'h20, 7'h20, 7'h00, 7'h01, 7'h00,
                                          7'h20, 7'h04, 7'h40, 7'h00, 7'h40};
  logic [6:0]              expLo [10] = '{7'h10, 7'h20, 7'h00, 7'h20, 7'h20,
                                          7'h02, 7'h20, 7'h40, 7'h20, 7'h40};

  supply_rails_model rails (.clk(clk), .level(level), .pinDrv(pinDrv), .pinVal(pinVal),
    .pullDn(pullDownEn), .above1v2(above1v2), .above2v7(above2v7), .pin(logicPin));

  supply_input_conditioning uut (.clk(clk), .rstn(rstn), .supplyCode(supplyCode),
    .logicPin(logicPin), .supplyAbove1v2(above1v2), .supplyAbove2v7(above2v7),
    .cfgLatch(cfgLatch), .chanCfgIn(chanCfg), .dualCfgIn(dualCfg), .outCfgIn(outCfg),
    .engineData(engineData), .smbusData(smbusData), .faultStatus_q(faultStatus),
    .warnStatus_q(warnStatus), .warning_q(warning), .logicOut_q(logicOut),
    .pullDownEn_q(pullDownEn), .drive_q(drive), .configured_q(configured));

  initial forever #12.5 clk = ~clk;

  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hangs are cut short well beyond the little over a thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic code(input int ch, input logic [7:0] v);
    @(negedge clk);
    supplyCode[ch] = v;
  endtask

  task automatic pinSet(input int j, input logic d, input logic v);
    @(negedge clk);
    pinDrv[j] = d;
    pinVal[j] = v;
  endtask

  task automatic highCount(input int j, input int k, output int c);
    c = 0;
    repeat (k) begin
      @(negedge clk);
      if (logicOut[j] === 1'b1) c++;
    end
  endtask

  task automatic waitToggle(output int c);
    prev = drive[2].strongUpVdd;
    c = 0;
    while (drive[2].strongUpVdd === prev && c < 300) begin
      cyc(1);
      c++;
    end
  endtask

  // Reset, supply ramp and one configuration latch with whatever is presented
  task automatic powerUp;
    rstn = 1'b0;
    level = 2'h0;
    cyc(5);
    rstn = 1'b1;
    cyc(6);
    check(drive, '0);
    level = 2'h1;
    cyc(6);
    check(drive, {10{7'h40}});
    level = 2'h2;
    cyc(4);
    cfgLatch = 1'b1;
    cyc(1);
    cfgLatch = 1'b0;
    cyc(4);
    check(configured, 1'b1);
  endtask

  initial begin
    supplyCode = {10{8'h80}};
    supplyCode[5] = 8'h00;
    pinDrv = '1;
    pinVal = '0;
    level = 2'h0;
    cfgLatch = 1'b0;
    chanCfg = '0;
    dualCfg = '0;
    outCfg = '0;
    engineData = '0;
    smbusData = '0;
    powerUp;
    check(drive, {10{7'h40}});
    $display("test defaults done");
    chanCfg[0] = '{8'h64, 8'h00, 5'h0a, 1'b1, 1'b0, 7'h01};
    chanCfg[1] = '{8'h00, 8'hc8, 5'h05, 1'b0, 1'b1, 7'h00};
    chanCfg[5] = '{8'h6e, 8'h00, 5'h00, 1'b1, 1'b0, 7'h00};
    chanCfg[7].filtUs = 7'h01;
    dualCfg[0] = '{1'b1, 1'b0, 1'b1, 7'h00};
    dualCfg[1] = '{1'b1, 1'b1, 1'b0, 7'h01};
    dualCfg[2].logicMode = 1'b1;
    dualCfg[3].pullDnEn = 1'b1;
    outCfg[0] = '{sic_pkg::SRC_SMBUS, sic_pkg::PULL_WEAK_VDD};
    outCfg[1] = '{sic_pkg::SRC_ENGINE, sic_pkg::PULL_STRONG_GND};
    outCfg[2] = '{sic_pkg::SRC_CLOCK, sic_pkg::PULL_STRONG_VDD};
    outCfg[3] = '{sic_pkg::SRC_ENGINE, sic_pkg::PULL_PUMP};
    outCfg[4] = '{sic_pkg::SRC_ENGINE, sic_pkg::PULL_OPEN_DRAIN};
    outCfg[5] = '{sic_pkg::SRC_SMBUS, sic_pkg::PULL_STRONG_RAIL};
    outCfg[6] = '{sic_pkg::SRC_ENGINE, sic_pkg::PULL_WEAK_RAIL};
    outCfg[7] = '{sic_pkg::SRC_ENGINE, sic_pkg::PULL_PUMP};
    outCfg[8] = '{sic_pkg::SRC_RSVD, sic_pkg::PULL_OPEN_DRAIN};
    powerUp;
    for (int p = 1; p >= 0; p--) begin
      engineData = {10{p[0]}};
      smbusData = {10{!p[0]}};
      cyc(3);
      for (int i = 0; i < 10; i++)
        if (i != 2) check(drive[i], p[0] ? expHi[i] : expLo[i]);
    end
    waitToggle(n);
    waitToggle(n);
    check(n, 200);
    $display("test drivers done");
    // A dip shorter than the 40-cycle timeout must vanish
    code(0, 8'h32);
    cyc(20);
    code(0, 8'h80);
    cyc(60);
    check(faultStatus[0], 1'b0);
    code(0, 8'h63);
    cyc(39);
    check(faultStatus[0], 1'b0);
    check({faultStatus[5], warning, warnStatus}, 7'h21);
    cyc(6);
    check(faultStatus[0], 1'b1);
    code(0, 8'h69);
    cyc(60);
    check({faultStatus[0], warning}, 2'h3);
    code(0, 8'h6f);
    cyc(60);
    check({faultStatus[0], warning, warnStatus}, 7'h00);
    check(faultStatus[5], 1'b0);
    code(1, 8'hc9);
    cyc(10);
    check(faultStatus[1], 1'b1);
    code(1, 8'hc4);
    cyc(10);
    check(faultStatus[1], 1'b1);
    code(1, 8'hc2);
    cyc(10);
    check(faultStatus[1], 1'b0);
    $display("test detectors done");
    pinSet(0, 1'b1, 1'b1);
    cyc(10);
    check(logicOut[0], 1'b1);
    pinSet(0, 1'b0, 1'b0);
    cyc(10);
    check(logicOut[0], 1'b0);
    check(pullDownEn, 5'h01);
    pinSet(1, 1'b1, 1'b1);
    highCount(1, 100, n);
    check(n, 40);
    pinSet(1, 1'b1, 1'b0);
    highCount(1, 100, n);
    check(n, 40);
    pinSet(2, 1'b1, 1'b1);
    cyc(20);
    pinSet(2, 1'b1, 1'b0);
    highCount(2, 100, n);
    check(n, 0);
    pinSet(2, 1'b1, 1'b1);
    cyc(60);
    check(logicOut[2], 1'b1);
    $display("test logic inputs done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
